// ### hw/scp_pkg.sv
// Constants and carrier types for the switchgear command and position block.
// Assumes a single 125 MHz clock and synchronous active-high reset.
//
// Operation
// R1 - Protection trips route by default to switchgear one, which needs break capability.
// R2 - Operator-controllable switchgear accepts and executes manual switching commands.
// R3 - Break capability without control: trips still pass, manual commands refused.
// R4 - Neither property: position reported only, no commands issued.
// R5 - Closed input true means closed; earthing part reads it as earthed.
// R6 - Open input true means open; disconnector-earthing reads it as earthed.
// R7 - Ready input true reports breaker ready, offered to other functions.
// R8 - Removed input true reports withdrawable breaker as withdrawn.
// R9 - Separate configurable travel times for reaching closed and open.
// R10 - Controllable switchgear provides close and open command outputs.
// R11 - Controllable switchgear accepts external close and open requests.
// R12 - Close rejected while any of three close interlocks is true.
// R13 - Open rejected while any of three open interlocks is true.
// R14 - Break-capable switchgear trips when any trip source becomes true.
// R15 - Trip stays asserted at least the trip hold time.
// R16 - Optional latched trip stays until trip acknowledge clears it.
// R17 - Position code: 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// R18 - Invisible switchgear is monitored but refuses front-panel commands.
// R19 - Indeterminate while travelling; disturbed and event on bad end state.
package scp_pkg;

    // --------------------------------------------------------------------
    // Position codes and timing
    // --------------------------------------------------------------------
    localparam logic [1:0] SCP_POS_INDET   = 2'h0;
    localparam logic [1:0] SCP_POS_OPEN    = 2'h1;
    localparam logic [1:0] SCP_POS_CLOSED  = 2'h2;
    localparam logic [1:0] SCP_POS_DISTURB = 2'h3;

    localparam int SCP_CLK_MHZ      = 125;
    localparam int SCP_NUM_INTERL   = 3;
    localparam int SCP_NUM_TRIP     = 8;
    localparam int SCP_TIME_W       = 32;
    localparam int SCP_CMD_PULSE_US = 1;
    localparam int SCP_CMD_PULSE_CY = SCP_CMD_PULSE_US * SCP_CLK_MHZ;
    localparam int SCP_SYNC_W       = 4 + 2 * SCP_NUM_INTERL + SCP_NUM_TRIP + 1 + 4;

    // Configuration word
    typedef struct packed {
        logic                  break_capable;
        logic                  controllable;
        logic                  invisible;
        logic                  earth_on_close;
        logic                  earth_on_open;
        logic                  trip_latched;
        logic [SCP_TIME_W-1:0] move_close_cycles;
        logic [SCP_TIME_W-1:0] move_open_cycles;
        logic [SCP_TIME_W-1:0] trip_hold_cycles;
    } scp_cfg_t;

    // Auxiliary contact inputs
    typedef struct packed {
        logic aux_closed;
        logic aux_open;
        logic ready;
        logic removed;
    } scp_aux_t;

    // Status word
    typedef struct packed {
        logic [1:0] position;
        logic       earthed;
        logic       ready;
        logic       withdrawn;
        logic       travelling;
    } scp_status_t;

endpackage : scp_pkg

// ### hw/scp_switchgear.sv
// Command gating, trip management and position supervision for one switchgear.
// Assumes aux contacts, interlocks, trip sources and external requests are
// asynchronous pins; panel requests and configuration come from mclk logic.
`timescale 1ns/1ps
module scp_switchgear
    import scp_pkg::*;
#(
    parameter int NUM_TRIP = SCP_NUM_TRIP,
    parameter int UNIT_NUM = 1
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // Configuration
    input  wire scp_cfg_t            cfg,
    // Auxiliary contacts (pins)
    input  wire scp_aux_t            aux,
    // Interlocks (pins)
    input  wire logic [2:0]          close_interlock_source,
    input  wire logic [2:0]          open_interlock_source,
    // Trip sources and acknowledge (pins)
    input  wire logic [NUM_TRIP-1:0] trip_source_signal,
    input  wire logic                trip_acknowledge,
    // External requests (pins)
    input  wire logic                external_close_request,
    input  wire logic                external_open_request,
    // Front-panel manual requests (one-cycle pulses, mclk domain)
    input  wire logic                panel_close_request,
    input  wire logic                panel_open_request,
    // Command outputs
    output logic                     close_cmd,
    output logic                     open_cmd,
    output logic                     trip_cmd,
    // Status and events
    output scp_status_t              status,
    output logic                     close_rejected,
    output logic                     open_rejected,
    output logic                     supervision_event,
    output logic                     config_fault
);

    // Refuse more trip sources than the synchroniser bank carries
    if (NUM_TRIP < 1 || NUM_TRIP > SCP_NUM_TRIP) begin : g_num_trip_check
        $error("scp_switchgear: NUM_TRIP out of range");
    end

    typedef enum logic [2:0] {
        SCP_ST_IDLE    = 3'b001,
        SCP_ST_CLOSING = 3'b010,
        SCP_ST_OPENING = 3'b100
    } scp_state_t;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [SCP_SYNC_W-1:0] sync_in;
    logic [SCP_SYNC_W-1:0] sync_out;
    logic [NUM_TRIP-1:0]   trip_src_pad;

    assign trip_src_pad = trip_source_signal;
    assign sync_in = {aux, close_interlock_source, open_interlock_source,
                      SCP_NUM_TRIP'(trip_src_pad), trip_acknowledge,
                      external_close_request, external_open_request, 2'h0};

    scp_sync #(.WIDTH(SCP_SYNC_W)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (sync_in),
        .dout (sync_out)
    );

    scp_aux_t                s_aux;
    logic [2:0]              s_cil;
    logic [2:0]              s_oil;
    logic [SCP_NUM_TRIP-1:0] s_trip;
    logic                    s_ack;
    logic                    s_ext_close;
    logic                    s_ext_open;

    assign s_aux       = sync_out[SCP_SYNC_W-1 -: 4];
    assign s_cil       = sync_out[SCP_SYNC_W-5 -: 3];
    assign s_oil       = sync_out[SCP_SYNC_W-8 -: 3];
    assign s_trip      = sync_out[SCP_SYNC_W-11 -: SCP_NUM_TRIP];
    assign s_ack       = sync_out[4];
    assign s_ext_close = sync_out[3];
    assign s_ext_open  = sync_out[2];

    // ----------------------------------------------------------------
    // Previous-cycle copies for edge detection
    // ----------------------------------------------------------------
    logic                    ext_close_d;
    logic                    ext_open_d;
    logic                    trip_any_d;
    logic                    trip_any;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_close_d <= 1'b0;
            ext_open_d  <= 1'b0;
            trip_any_d  <= 1'b0;
        end else begin
            ext_close_d <= s_ext_close;
            ext_open_d  <= s_ext_open;
            trip_any_d  <= trip_any;
        end
    end

    // ----------------------------------------------------------------
    // Position decode from auxiliary contacts
    // ----------------------------------------------------------------
    logic       pos_closed;
    logic       pos_open;
    logic       pos_earthed;
    logic [1:0] end_code;

    assign pos_closed  = s_aux.aux_closed & ~cfg.earth_on_close;       // see R5
    assign pos_open    = s_aux.aux_open & ~cfg.earth_on_open;          // see R6
    assign pos_earthed = (s_aux.aux_closed & cfg.earth_on_close)       // see R5
                       | (s_aux.aux_open & cfg.earth_on_open);         // see R6

    // Earthed counts as the "on" end for the earthing part, "off" end otherwise
    function automatic logic [1:0] scp_end_code(input logic on_end, input logic off_end);
        if (on_end && !off_end) begin
            scp_end_code = SCP_POS_CLOSED;
        end else if (off_end && !on_end) begin
            scp_end_code = SCP_POS_OPEN;
        end else if (on_end && off_end) begin
            scp_end_code = SCP_POS_DISTURB;
        end else begin
            scp_end_code = SCP_POS_INDET;
        end
    endfunction : scp_end_code

    assign end_code = scp_end_code(s_aux.aux_closed, s_aux.aux_open);  // see R17

    // ----------------------------------------------------------------
    // Command gating
    // ----------------------------------------------------------------
    logic trip_rise;
    logic manual_ok;
    logic ext_ok;
    logic close_req;
    logic open_req;
    logic close_block;
    logic open_block;
    logic close_go;
    logic open_go;

    assign trip_any  = cfg.break_capable & (|s_trip);                  // see R14
    assign trip_rise = trip_any & ~trip_any_d;                         // see R14
    // Panel operation needs control and visibility
    assign manual_ok = cfg.controllable & ~cfg.invisible;              // see R2, R3, R4, R18
    assign ext_ok    = cfg.controllable;                               // see R11, R4
    assign close_req = (manual_ok & panel_close_request)
                     | (ext_ok & s_ext_close & ~ext_close_d);          // see R11
    assign open_req  = (manual_ok & panel_open_request)
                     | (ext_ok & s_ext_open & ~ext_open_d);            // see R11
    assign close_block = |s_cil;                                       // see R12
    assign open_block  = |s_oil;                                       // see R13
    assign close_go  = close_req & ~close_block & ~open_req & ~trip_any;
    assign open_go   = open_req & ~open_block;

    // ----------------------------------------------------------------
    // Travel supervision state machine
    // ----------------------------------------------------------------
    scp_state_t            state;
    scp_state_t            next_state;
    logic [SCP_TIME_W-1:0] move_cnt;
    logic [SCP_TIME_W-1:0] next_move_cnt;
    logic                  move_done;
    logic                  start_open;

    assign start_open = open_go | trip_rise;
    assign move_done  = (move_cnt == '0);

    always_comb begin
        next_state    = state;
        next_move_cnt = (move_cnt != '0) ? move_cnt - 1'b1 : move_cnt;
        case (state)
            SCP_ST_IDLE, SCP_ST_CLOSING, SCP_ST_OPENING: begin
                if (start_open) begin
                    next_state    = SCP_ST_OPENING;
                    next_move_cnt = cfg.move_open_cycles;              // see R9
                end else if (close_go) begin
                    next_state    = SCP_ST_CLOSING;
                    next_move_cnt = cfg.move_close_cycles;             // see R9
                end else if (state != SCP_ST_IDLE && move_done) begin
                    next_state = SCP_ST_IDLE;
                end
            end
            default: begin
                next_state    = SCP_ST_IDLE;
                next_move_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state    <= SCP_ST_IDLE;
            move_cnt <= '0;
        end else begin
            state    <= next_state;
            move_cnt <= next_move_cnt;
        end
    end

    // Travel ends with neither or both end positions: disturbed
    logic travel_end;
    logic bad_end;
    logic disturbed;

    assign travel_end = (state != SCP_ST_IDLE) && move_done && !start_open && !close_go;
    assign bad_end    = (end_code == SCP_POS_INDET) || (end_code == SCP_POS_DISTURB);

    always_ff @(posedge mclk) begin
        if (rst) begin
            disturbed <= 1'b0;
        end else if (travel_end) begin
            disturbed <= bad_end;                                      // see R19
        end else if (!bad_end) begin
            disturbed <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Command pulse stretch for close/open relays
    // ----------------------------------------------------------------
    logic [SCP_TIME_W-1:0] pulse_cnt;
    logic                  pulse_close;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pulse_cnt   <= '0;
            pulse_close <= 1'b0;
        end else if (open_go || close_go) begin
            pulse_cnt   <= SCP_TIME_W'(SCP_CMD_PULSE_CY);
            pulse_close <= close_go;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Trip manager: hold time and optional latch
    // ----------------------------------------------------------------
    logic [SCP_TIME_W-1:0] hold_cnt;
    logic                  trip_latch;
    logic                  next_trip;

    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_cnt <= '0;
        end else if (trip_any) begin
            hold_cnt <= cfg.trip_hold_cycles;                          // see R15
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;                               // see R15
        end
    end

    // Latch set wins over acknowledge
    always_ff @(posedge mclk) begin
        if (rst) begin
            trip_latch <= 1'b0;
        end else if (cfg.trip_latched && trip_any) begin
            trip_latch <= 1'b1;                                        // see R16
        end else if (s_ack || !cfg.trip_latched) begin
            trip_latch <= 1'b0;                                        // see R16
        end
    end

    assign next_trip = cfg.break_capable
                     & (trip_any | (hold_cnt != '0) | trip_latch);     // see R14, R1

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            close_cmd         <= 1'b0;
            open_cmd          <= 1'b0;
            trip_cmd          <= 1'b0;
            close_rejected    <= 1'b0;
            open_rejected     <= 1'b0;
            supervision_event <= 1'b0;
            config_fault      <= 1'b0;
            status            <= '0;
        end else begin
            close_cmd <= cfg.controllable & (close_go |
                         (pulse_close & (pulse_cnt > 1)));             // see R10
            open_cmd  <= cfg.controllable & (open_go |
                         (!pulse_close & (pulse_cnt > 1)));            // see R10
            trip_cmd          <= next_trip;
            close_rejected    <= close_req & close_block;              // see R12
            open_rejected     <= open_req & open_block;                // see R13
            supervision_event <= travel_end & bad_end;                 // see R19
            config_fault      <= (UNIT_NUM == 1) && !cfg.break_capable; // see R1
            status.position   <= (state != SCP_ST_IDLE) ? SCP_POS_INDET :
                                 disturbed ? SCP_POS_DISTURB : end_code; // see R17, R19
            status.earthed    <= pos_earthed;
            status.ready      <= s_aux.ready;                          // see R7
            status.withdrawn  <= s_aux.removed;                        // see R8
            status.travelling <= (state != SCP_ST_IDLE);
        end
    end

    // Unused decode terms kept visible for status tools
    logic unused_ok;
    assign unused_ok = pos_closed ^ pos_open;

endmodule : scp_switchgear

// ### hw/scp_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ps
module scp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    // ----------------------------------------------------------------
    // Two stages; the first is read only by the second
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : scp_sync

// ### verif/scp_breaker_model.sv
// Breaker mechanism: moves its auxiliary contacts in answer to commands.
// Assumes registered commands; a stuck mechanism never reaches an end.
`timescale 1ns/1ps
module scp_breaker_model
    import scp_pkg::*;
(
    // Clock
    input  wire logic       mclk,
    // Commands and scenario controls
    input  wire logic       close_cmd,
    input  wire logic       open_cmd,
    input  wire logic       trip_cmd,
    input  wire logic       stuck,
    input  wire logic       rack_out,
    input  wire logic [7:0] delay,
    // Contacts
    output scp_aux_t        aux
);
    logic [2:0] prev = 3'h0;
    logic [7:0] cnt  = 8'h0;
    logic       goal = 1'b0;
    logic       move = 1'b0;
    logic       arr  = 1'b1;
    wire        c_go = close_cmd && !prev[2];
    wire        o_go = (open_cmd && !prev[1]) || (trip_cmd && !prev[0]);

    // Both contacts low in mid-travel; open wins over close
    always @(posedge mclk) begin
        prev <= {close_cmd, open_cmd, trip_cmd};
        if (c_go || o_go) begin
            goal <= c_go && !o_go;
            move <= 1'b1;
            arr  <= 1'b0;
            cnt  <= 8'h0;
        end else if (move) begin
            cnt <= cnt + 8'h1;
            if (cnt == delay) begin
                move <= 1'b0;
                arr  <= !stuck;
            end
        end
    end
    assign aux = {arr && goal, arr && !goal, !move, rack_out};
endmodule : scp_breaker_model

// ### verif/scp_sva.sv
// Concurrent checks on the ports of one switchgear block.
// Assumes binding to scp_switchgear and a bench that holds cfg steady.
`timescale 1ns/1ps
module scp_sva
    import scp_pkg::*;
#(
    parameter int UNIT_NUM = 1
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // Inputs watched
    input wire scp_cfg_t    cfg,
    input wire scp_aux_t    aux,
    input wire logic [2:0]  close_interlock_source,
    input wire logic [2:0]  open_interlock_source,
    input wire logic        trip_acknowledge,
    // Outputs watched
    input wire logic        close_cmd,
    input wire logic        open_cmd,
    input wire logic        trip_cmd,
    input wire scp_status_t status,
    input wire logic        config_fault
);
    // Length of the current trip pulse
    logic [31:0] trip_len;
    always_ff @(posedge mclk) begin
        if (rst || !trip_cmd)
            trip_len <= 32'h0;
        else
            trip_len <= trip_len + 32'h1;
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    a_close_gate: assert property (
        $rose(close_cmd) |-> cfg.controllable && close_interlock_source == 3'h0)
        else $error("close command while not allowed");
    a_open_gate: assert property (
        $rose(open_cmd) |-> open_interlock_source == 3'h0)
        else $error("open command while interlocked");
    a_monitor_quiet: assert property (
        ($rose(close_cmd) || $rose(open_cmd) || $rose(trip_cmd))
        |-> cfg.controllable || cfg.break_capable)
        else $error("command issued by a monitored unit");
    a_trip_hold: assert property (
        $fell(trip_cmd) |-> trip_len >= cfg.trip_hold_cycles)
        else $error("trip shorter than hold time");
    a_latch_keep: assert property (
        (cfg.trip_latched && trip_cmd && !trip_acknowledge)[*5] |=> trip_cmd)
        else $error("latched trip dropped without acknowledge");
    a_pos_code: assert property (
        (!status.travelling && !cfg.earth_on_close && !cfg.earth_on_open
         && aux.aux_closed != aux.aux_open && $stable(aux))[*6]
        |-> status.position == (aux.aux_closed ? SCP_POS_CLOSED : SCP_POS_OPEN))
        else $error("position code does not follow contacts");
    a_travel_indet: assert property (
        status.travelling |-> status.position == SCP_POS_INDET)
        else $error("position not indeterminate while travelling");
    a_status_bits: assert property (
        ($stable(aux.ready) && $stable(aux.removed))[*6]
        |-> status.ready == aux.ready && status.withdrawn == aux.removed)
        else $error("ready or withdrawn status wrong");
    a_unit_one_cfg: assert property (
        (UNIT_NUM == 1 && !cfg.break_capable)[*4] |-> config_fault)
        else $error("unit one without break capability not flagged");

    // Main scenarios reached
    c_trip: cover property ($rose(trip_cmd));
    c_close: cover property ($rose(close_cmd));
    c_disturb: cover property (status.position == SCP_POS_DISTURB);
endmodule : scp_sva

// ### verif/tb_switchgear_command_position.sv
// Self-checking bench for the switchgear command and position block.
// Assumes the breaker model on the contacts and the checker bound below.
`timescale 1ns/1ps
module tb_switchgear_command_position;
    import scp_pkg::*;
    scp_cfg_t    cfg;
    scp_aux_t    aux;
    scp_status_t status;
    logic [2:0]  cil, oil;
    logic [7:0]  trip_src;
    logic        mclk, rst, ack, ext_c, ext_o, pnl_c, pnl_o, stuck, rack_out;
    logic        close_cmd, open_cmd, trip_cmd, close_rej, open_rej, sup_ev, cfg_fault;
    int          miscompares, tests_run;

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    scp_switchgear #(.NUM_TRIP(8), .UNIT_NUM(1)) i_dut (
        .mclk(mclk), .rst(rst), .cfg(cfg), .aux(aux),
        .close_interlock_source(cil), .open_interlock_source(oil),
        .trip_source_signal(trip_src), .trip_acknowledge(ack),
        .external_close_request(ext_c), .external_open_request(ext_o),
        .panel_close_request(pnl_c), .panel_open_request(pnl_o),
        .close_cmd(close_cmd), .open_cmd(open_cmd), .trip_cmd(trip_cmd),
        .status(status), .close_rejected(close_rej), .open_rejected(open_rej),
        .supervision_event(sup_ev), .config_fault(cfg_fault));

    scp_breaker_model i_brk (
        .mclk(mclk), .close_cmd(close_cmd), .open_cmd(open_cmd),
        .trip_cmd(trip_cmd), .stuck(stuck), .rack_out(rack_out),
        .delay(8'h0A), .aux(aux));

    // f = {break capable, controllable, invisible, latched}
    function automatic scp_cfg_t mk(input logic [3:0] f);
        return '{f[3], f[2], f[1], 1'b0, 1'b0, f[0], 32'h28, 32'h50, 32'h14};
    endfunction : mk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    function automatic logic pick(input int k);
        return k == 0 ? close_cmd : k == 1 ? open_cmd : k == 2 ? trip_cmd :
               k == 3 ? close_rej : k == 4 ? open_rej : sup_ev;
    endfunction : pick

    // Watch one output for n cycles and compare whether it went high
    task automatic seen(input int k, input int n, input logic exp);
        logic hit;
        #1;
        hit = (pick(k) === 1'b1);
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (pick(k) === 1'b1)
                hit = 1'b1;
        end
        chk(hit, exp);
    endtask : seen

    // One-cycle front-panel request, close when c is high
    task automatic panel(input logic c);
        @(posedge mclk);
        pnl_c <= c;
        pnl_o <= !c;
        @(posedge mclk);
        pnl_c <= 1'b0;
        pnl_o <= 1'b0;
    endtask : panel

    task automatic setcfg(input logic [3:0] f);
        @(posedge mclk);
        cfg <= mk(f);
        repeat (6) @(posedge mclk);
    endtask : setcfg

    task automatic trip_pulse(input logic [7:0] s);
        trip_src <= s;
        repeat (3) @(posedge mclk);
        trip_src <= 8'h00;
    endtask : trip_pulse

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        results();
    end

    initial begin
        {cil, oil, trip_src, ack, ext_c, ext_o, pnl_c, pnl_o} <= '0;
        {stuck, rack_out} <= 2'h0;
        rst <= 1'b1;
        cfg <= mk(4'hC);
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 chk({close_cmd, open_cmd, trip_cmd, cfg_fault}, 4'h0);
        repeat (8) @(posedge mclk);
        #1 chk(status.position, SCP_POS_OPEN);
        // Manual close then open, with separate travel times
        panel(1'b1);
        seen(0, 4, 1'b1);
        chk({status.travelling, status.position}, {1'b1, SCP_POS_INDET});
        repeat (50) @(posedge mclk);
        #1 chk(status.position, SCP_POS_CLOSED);
        repeat (90) @(posedge mclk);
        panel(1'b0);
        seen(1, 60, 1'b1);
        chk(status.travelling, 1'b1);
        repeat (30) @(posedge mclk);
        #1 chk(status.position, SCP_POS_OPEN);
        repeat (100) @(posedge mclk);
        // External requests
        ext_c <= 1'b1;
        seen(0, 8, 1'b1);
        ext_c <= 1'b0;
        repeat (200) @(posedge mclk);
        ext_o <= 1'b1;
        seen(1, 8, 1'b1);
        ext_o <= 1'b0;
        repeat (200) @(posedge mclk);
        // Each interlock input blocks its direction
        for (int i = 0; i < 3; i++) begin
            cil <= 3'h1 << i;
            oil <= 3'h1 << i;
            repeat (4) @(posedge mclk);
            panel(1'b1);
            seen(3, 4, 1'b1);
            chk(close_cmd, 1'b0);
            panel(1'b0);
            seen(4, 4, 1'b1);
            chk(open_cmd, 1'b0);
        end
        {cil, oil} <= 6'h00;
        // Mechanism stuck in mid-travel
        stuck <= 1'b1;
        repeat (4) @(posedge mclk);
        panel(1'b1);
        seen(5, 60, 1'b1);
        chk(status.position, SCP_POS_DISTURB);
        stuck <= 1'b0;
        repeat (100) @(posedge mclk);
        panel(1'b0);
        repeat (220) @(posedge mclk);
        // Break capable only: manual refused, every trip source trips
        setcfg(4'h8);
        panel(1'b1);
        seen(0, 10, 1'b0);
        for (int k = 0; k < 8; k++) begin
            trip_pulse(8'h01 << k);
            repeat (15) @(posedge mclk);
            #1 chk(trip_cmd, 1'b1);
            repeat (15) @(posedge mclk);
            #1 chk(trip_cmd, 1'b0);
        end
        // Latched trip waits for acknowledge
        setcfg(4'h9);
        trip_pulse(8'h80);
        repeat (60) @(posedge mclk);
        #1 chk(trip_cmd, 1'b1);
        ack <= 1'b1;
        repeat (4) @(posedge mclk);
        ack <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 chk(trip_cmd, 1'b0);
        // Monitor only: no trip or close issued, unit one flagged
        setcfg(4'h0);
        chk(cfg_fault, 1'b1);
        trip_pulse(8'h01);
        seen(2, 10, 1'b0);
        panel(1'b1);
        seen(0, 10, 1'b0);
        // Invisible: panel refused, external request still acts
        setcfg(4'hE);
        panel(1'b1);
        seen(0, 10, 1'b0);
        ext_c <= 1'b1;
        seen(0, 8, 1'b1);
        ext_c <= 1'b0;
        rack_out <= 1'b1;
        repeat (200) @(posedge mclk);
        #1 chk({status.ready, status.withdrawn, status.earthed}, 3'h6);
        results();
    end
endmodule : tb_switchgear_command_position

bind scp_switchgear scp_sva #(.UNIT_NUM(UNIT_NUM)) i_sva (
    .mclk(mclk), .rst(rst), .cfg(cfg), .aux(aux),
    .close_interlock_source(close_interlock_source),
    .open_interlock_source(open_interlock_source),
    .trip_acknowledge(trip_acknowledge), .close_cmd(close_cmd),
    .open_cmd(open_cmd), .trip_cmd(trip_cmd), .status(status),
    .config_fault(config_fault));
